// ---- rtl/rsq_top.sv ----
// Receive signal qualifier: sync acceptance, signal-strength hold, carrier sense,
// clear-channel assessment and transmit-if-clear strobe gating.
// Assumes all inputs come from logic on clk; configuration is loaded by a one-cycle strobe.
//
// Operation
// - With sync search on, no byte reaches the receive FIFO before sync qualifies.
// - Qualifier codes 0-3: no search, 15 of 16, 16 of 16, 30 of 32.
// - Codes 4-7 use the same criteria and also demand carrier sense.
// - With sync search on, strength value tracks until sync, then holds until receive is entered again.
// - Strength value is 8-bit two's complement in half-dB units.
// - Estimate refreshes once per 2^filter_len raw samples at 2*BW/8.
// - With append on, the first status byte carries the packet's last strength.
// - Absolute sense asserts above threshold, deasserts below it, with hysteresis.
// - Relative sense asserts on a rise by the step, deasserts on a like drop.
// - Relative field: off, 6 dB, 10 dB or 14 dB.
// - Absolute offset moves the threshold by up to 7 dB either way, 1 dB steps.
// - Absolute offset resets to the 0 dB code.
// - Carrier sense shows on a pin with function 14 and in packet status.
// - Clear-channel state shows on a pin with function 0x09.
// - Transmit or synth strobes in receive are honoured only when clear.
// - A refused strobe is forgotten; the host must strobe again.
// - Clear-channel select: always, strength low, no packet, or both.
`timescale 1ns/1ps
module rsq_top
    import rsq_pkg::*;
#(
    parameter int MAX_FL = RSQ_FL_MAX
)
(
    // Clock and reset.
    input  wire logic                          clk,
    input  wire logic                          nrst,
    // Configuration.
    input  wire logic                          cfg_load,
    input  wire rsq_cfg_t                      cfg_in,
    input  wire logic signed [RSQ_RSSI_W-1:0]  sense_base_thr,
    // Radio control.
    input  wire logic                          rx_state,
    input  wire logic                          transmit_strobe,
    input  wire logic                          synth_on_strobe,
    // Channel level and sync correlator.
    input  wire logic                          level_valid,
    input  wire logic signed [RSQ_RSSI_W-1:0]  level,
    input  wire logic                          sync_cand,
    input  wire logic [RSQ_MATCH_W-1:0]        sync_match,
    // Demodulated data.
    input  wire rsq_byte_t                     rx_in,
    input  wire logic                          payload_end,
    // Data and status out.
    output rsq_byte_t                          rx_fifo_wr,
    output rsq_byte_t                          status_byte,
    output logic                               pkt_filter_en,
    output logic                               sync_found,
    output logic [RSQ_RSSI_W-1:0]              rssi_status,
    // Qualifiers.
    output logic                               carrier_sense,
    output logic                               sense_status_bit,
    output logic                               clear_channel,
    // State requests.
    output logic                               enter_tx,
    output logic                               enter_synth_ready_state,
    output logic                               strobe_refused,
    // Pins.
    output logic [RSQ_PINS-1:0]                general_output_pin
);

    if (MAX_FL < 1 || MAX_FL > RSQ_FL_MAX)
    begin : g_bad_fl
        $error("rsq_top: MAX_FL out of range");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration.

    rsq_cfg_t cfg_reg;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cfg_reg <= RSQ_CFG_RST;
        end
        else if (cfg_load)
        begin
            cfg_reg <= cfg_in;
        end
    end

    logic [1:0] sync_crit;
    logic       sync_need_cs;
    logic       sync_enabled;

    assign sync_crit    = cfg_reg.sync_mode[1:0];
    assign sync_need_cs = cfg_reg.sync_mode[RSQ_SYNC_CS_BIT];
    assign sync_enabled = (sync_crit != RSQ_SYNC_NONE);

    ////////////////////////////////////////////////////////////////////////////////
    // Signal-strength estimate.

    logic                          rx_state_d_reg;
    logic                          rx_entry;
    logic                          avg_valid;
    logic signed [RSQ_RSSI_W-1:0]  avg;

    assign rx_entry = rx_state && !rx_state_d_reg;

    rsq_rssi_avg #(
        .MAX_FL      (MAX_FL)
    ) u_avg (
        .clk         (clk),
        .nrst        (nrst),
        .run         (rx_state),
        .filter_len  (cfg_reg.filter_len),
        .level_valid (level_valid),
        .level       (level),
        .avg_valid   (avg_valid),
        .avg         (avg)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Carrier sense.

    logic signed [8:0]  abs_thr;
    logic signed [8:0]  abs_low;
    logic signed [8:0]  avg_w;
    logic signed [8:0]  delta;
    logic signed [8:0]  rel_step;
    logic               abs_en;
    logic               rel_en;
    logic               abs_cs_reg;
    logic               abs_cs_next;
    logic               rel_cs_reg;
    logic               rel_cs_next;
    logic               prev_ok_reg;
    logic signed [RSQ_RSSI_W-1:0] prev_reg;
    logic               cs_next;

    assign avg_w   = 9'(avg);
    assign abs_thr = 9'(sense_base_thr)
                   + (9'(cfg_reg.absolute_sense_offset) <<< RSQ_HALF_DB_SHIFT);
    assign abs_low = abs_thr - RSQ_HYST_HALF_DB;
    assign abs_en  = (cfg_reg.absolute_sense_offset != RSQ_ABS_OFF_DIS);
    assign abs_cs_next = !abs_en          ? 1'b0 :
                         (avg_w > abs_thr) ? 1'b1 :
                         (avg_w < abs_low) ? 1'b0 :
                         abs_cs_reg;

    assign rel_step = (cfg_reg.relative_sense_step == RSQ_REL_6DB)  ? RSQ_STEP_6DB :
                      (cfg_reg.relative_sense_step == RSQ_REL_10DB) ? RSQ_STEP_10DB :
                      RSQ_STEP_14DB;
    assign rel_en   = (cfg_reg.relative_sense_step != RSQ_REL_OFF);
    assign delta    = avg_w - 9'(prev_reg);
    assign rel_cs_next = !rel_en              ? 1'b0 :
                         !prev_ok_reg         ? rel_cs_reg :
                         (delta >= rel_step)  ? 1'b1 :
                         (delta <= -rel_step) ? 1'b0 :
                         rel_cs_reg;

    assign cs_next = abs_cs_reg || rel_cs_reg;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            abs_cs_reg  <= 1'b0;
            rel_cs_reg  <= 1'b0;
            prev_ok_reg <= 1'b0;
            prev_reg    <= '0;
        end
        else if (!rx_state)
        begin
            abs_cs_reg  <= 1'b0;
            rel_cs_reg  <= 1'b0;
            prev_ok_reg <= 1'b0;
        end
        else if (avg_valid)
        begin
            abs_cs_reg  <= abs_cs_next;
            rel_cs_reg  <= rel_cs_next;
            prev_ok_reg <= 1'b1;
            prev_reg    <= avg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sync qualification.

    rsq_rx_state_t  state_reg;
    rsq_rx_state_t  state_next;
    logic           match_ok;
    logic           qualify;

    assign match_ok = (sync_crit == RSQ_SYNC_NONE)  ? 1'b1 :
                      (sync_crit == RSQ_SYNC_15_16) ? sync_cand && (sync_match >= RSQ_MATCH_15) :
                      (sync_crit == RSQ_SYNC_16_16) ? sync_cand && (sync_match >= RSQ_MATCH_16) :
                      sync_cand && (sync_match >= RSQ_MATCH_30);
    assign qualify  = match_ok && (!sync_need_cs || carrier_sense);

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            RSQ_RX_IDLE:
            begin
                if (rx_state)
                begin
                    state_next = RSQ_RX_SEARCH;
                end
            end
            RSQ_RX_SEARCH:
            begin
                if (qualify)
                begin
                    state_next = RSQ_RX_PACKET;
                end
            end
            RSQ_RX_PACKET:
            begin
                if (payload_end)
                begin
                    state_next = RSQ_RX_SEARCH;
                end
            end
            default:
            begin
                state_next = RSQ_RX_IDLE;
            end
        endcase
        if (!rx_state)
        begin
            state_next = RSQ_RX_IDLE;
        end
    end

    logic in_packet;
    logic searching;
    logic fifo_wr_next;

    assign in_packet    = (state_reg == RSQ_RX_PACKET);
    assign searching    = (state_reg == RSQ_RX_SEARCH) && rx_state;
    assign fifo_wr_next = rx_in.valid && in_packet && rx_state;

    ////////////////////////////////////////////////////////////////////////////////
    // Strength status, freeze and status append.

    logic                          freeze_reg;
    logic signed [RSQ_RSSI_W-1:0]  last_reg;
    logic                          append;

    assign append = payload_end && in_packet && cfg_reg.status_append_enable;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg      <= RSQ_RX_IDLE;
            rx_state_d_reg <= 1'b0;
            freeze_reg     <= 1'b0;
            last_reg       <= '0;
            rssi_status    <= '0;
            sync_found     <= 1'b0;
            pkt_filter_en  <= 1'b0;
            rx_fifo_wr     <= '0;
            status_byte    <= '0;
        end
        else
        begin
            state_reg      <= state_next;
            rx_state_d_reg <= rx_state;
            sync_found     <= searching && qualify;
            pkt_filter_en  <= (state_next == RSQ_RX_PACKET);
            rx_fifo_wr     <= '{valid: fifo_wr_next, data: rx_in.data};
            if (rx_entry)
            begin
                freeze_reg <= 1'b0;
            end
            else if (searching && qualify && sync_enabled)
            begin
                freeze_reg <= 1'b1;
            end
            if (avg_valid && rx_state)
            begin
                last_reg <= avg;
                if (!freeze_reg)
                begin
                    rssi_status <= avg;
                end
            end
            status_byte <= '{valid: append, data: last_reg};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clear channel and strobe gating.

    logic cca_next;
    logic in_rx;

    assign cca_next = (cfg_reg.clear_channel_select == RSQ_CCA_ALWAYS) ? 1'b1 :
                      (cfg_reg.clear_channel_select == RSQ_CCA_RSSI)   ? !carrier_sense :
                      (cfg_reg.clear_channel_select == RSQ_CCA_NO_PKT) ? !in_packet :
                      !carrier_sense && !in_packet;
    assign in_rx    = rx_state && rx_state_d_reg;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            carrier_sense           <= 1'b0;
            sense_status_bit        <= 1'b0;
            clear_channel           <= 1'b1;
            enter_tx                <= 1'b0;
            enter_synth_ready_state <= 1'b0;
            strobe_refused          <= 1'b0;
        end
        else
        begin
            carrier_sense           <= cs_next;
            sense_status_bit        <= cs_next;
            clear_channel           <= cca_next;
            // Strobes are acted on once and never queued.
            enter_tx                <= transmit_strobe && (!in_rx || clear_channel);
            enter_synth_ready_state <= synth_on_strobe && !transmit_strobe
                                       && (!in_rx || clear_channel);
            strobe_refused          <= (transmit_strobe || synth_on_strobe)
                                       && in_rx && !clear_channel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // General output pins.

    for (genvar p = 0; p < RSQ_PINS; p++)
    begin : g_pin
        rsq_out_mux u_mux (
            .clk           (clk),
            .nrst          (nrst),
            .func          (cfg_reg.output_pin_function[p]),
            .carrier_sense (carrier_sense),
            .clear_channel (clear_channel),
            .pin           (general_output_pin[p])
        );
    end

endmodule

// ---- rtl/rsq_pkg.sv ----
// Constants, field layouts and carrier types of the receive signal qualifier.
// Assumes one core clock shared by the radio core, the command decoder and this block.
package rsq_pkg;

    localparam int RSQ_RSSI_W = 8;
    localparam int RSQ_FL_W   = 2;
    localparam int RSQ_FL_MAX = 3;
    localparam int RSQ_PINS   = 3;
    localparam int RSQ_FUNC_W = 6;
    localparam int RSQ_MATCH_W = 6;

    // Qualifier field: low two bits pick the bit-match criterion, the top bit adds carrier sense.
    localparam logic [1:0] RSQ_SYNC_NONE  = 2'h0;
    localparam logic [1:0] RSQ_SYNC_15_16 = 2'h1;
    localparam logic [1:0] RSQ_SYNC_16_16 = 2'h2;
    localparam logic [1:0] RSQ_SYNC_30_32 = 2'h3;
    localparam int         RSQ_SYNC_CS_BIT = 2;
    localparam logic [RSQ_MATCH_W-1:0] RSQ_MATCH_15 = 6'h0f;
    localparam logic [RSQ_MATCH_W-1:0] RSQ_MATCH_16 = 6'h10;
    localparam logic [RSQ_MATCH_W-1:0] RSQ_MATCH_30 = 6'h1e;

    // Absolute offset field: signed whole dB, -8 switches absolute detection off.
    localparam logic signed [3:0] RSQ_ABS_OFF_ZERO = 4'sh0;
    localparam logic signed [3:0] RSQ_ABS_OFF_DIS  = 4'sh8;
    localparam int                RSQ_HALF_DB_SHIFT = 1;
    localparam logic signed [8:0] RSQ_HYST_HALF_DB = 9'sh002;

    // Relative step field and its steps in half-dB units.
    localparam logic [1:0] RSQ_REL_OFF  = 2'h0;
    localparam logic [1:0] RSQ_REL_6DB  = 2'h1;
    localparam logic [1:0] RSQ_REL_10DB = 2'h2;
    localparam logic [1:0] RSQ_REL_14DB = 2'h3;
    localparam logic signed [8:0] RSQ_STEP_6DB  = 9'sh00c;
    localparam logic signed [8:0] RSQ_STEP_10DB = 9'sh014;
    localparam logic signed [8:0] RSQ_STEP_14DB = 9'sh01c;

    // Clear-channel select field.
    localparam logic [1:0] RSQ_CCA_ALWAYS = 2'h0;
    localparam logic [1:0] RSQ_CCA_RSSI   = 2'h1;
    localparam logic [1:0] RSQ_CCA_NO_PKT = 2'h2;
    localparam logic [1:0] RSQ_CCA_BOTH   = 2'h3;

    // Output pin functions served here.
    localparam logic [RSQ_FUNC_W-1:0] RSQ_FUNC_CCA = 6'h09;
    localparam logic [RSQ_FUNC_W-1:0] RSQ_FUNC_CS  = 6'h0e;

    typedef enum logic [1:0] {
        RSQ_RX_IDLE   = 2'b00,
        RSQ_RX_SEARCH = 2'b01,
        RSQ_RX_PACKET = 2'b11
    } rsq_rx_state_t;

    typedef struct packed {
        logic [2:0]                             sync_mode;
        logic [RSQ_FL_W-1:0]                    filter_len;
        logic signed [3:0]                      absolute_sense_offset;
        logic [1:0]                             relative_sense_step;
        logic [1:0]                             clear_channel_select;
        logic                                   status_append_enable;
        logic [RSQ_PINS-1:0][RSQ_FUNC_W-1:0]    output_pin_function;
    } rsq_cfg_t;

    typedef struct packed {
        logic                   valid;
        logic [7:0]             data;
    } rsq_byte_t;

    localparam rsq_cfg_t RSQ_CFG_RST = '{
        sync_mode:             3'h2,
        filter_len:            2'h1,
        absolute_sense_offset: RSQ_ABS_OFF_ZERO,
        relative_sense_step:   RSQ_REL_OFF,
        clear_channel_select:  RSQ_CCA_BOTH,
        status_append_enable:  1'b1,
        output_pin_function:   {RSQ_PINS{6'h00}}
    };

endpackage

// ---- rtl/rsq_rssi_avg.sv ----
// Averaging filter that turns raw channel level samples into the signal-strength estimate.
// Assumes raw samples arrive as one-cycle strobes at twice the channel bandwidth over 8.
`timescale 1ns/1ps
module rsq_rssi_avg
    import rsq_pkg::*;
#(
    parameter int MAX_FL = RSQ_FL_MAX
)
(
    // Clock and reset.
    input  wire logic                          clk,
    input  wire logic                          nrst,
    // Control.
    input  wire logic                          run,
    input  wire logic [RSQ_FL_W-1:0]           filter_len,
    // Raw samples.
    input  wire logic                          level_valid,
    input  wire logic signed [RSQ_RSSI_W-1:0]  level,
    // Estimate.
    output logic                               avg_valid,
    output logic signed [RSQ_RSSI_W-1:0]       avg
);
    localparam int SUM_W = RSQ_RSSI_W + MAX_FL;

    if (MAX_FL < 1 || MAX_FL > RSQ_FL_MAX)
    begin : g_bad_fl
        $error("rsq_rssi_avg: MAX_FL out of range");
    end

    logic signed [SUM_W-1:0]  sum_reg;
    logic [MAX_FL:0]          cnt_reg;
    logic [RSQ_FL_W-1:0]      fl_eff;
    logic [MAX_FL:0]          cnt_last;
    logic signed [SUM_W-1:0]  sum_next;
    logic                     done;

    assign fl_eff   = (filter_len > RSQ_FL_W'(MAX_FL)) ? RSQ_FL_W'(MAX_FL) : filter_len;
    assign cnt_last = (MAX_FL+1)'((1 << fl_eff) - 1);
    assign sum_next = sum_reg + SUM_W'(level);
    assign done     = level_valid && (cnt_reg == cnt_last);

    // One estimate per 2^filter_len raw samples.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sum_reg   <= '0;
            cnt_reg   <= '0;
            avg_valid <= 1'b0;
            avg       <= '0;
        end
        else
        begin
            avg_valid <= run && done;
            if (!run || done)
            begin
                sum_reg <= '0;
                cnt_reg <= '0;
            end
            else if (level_valid)
            begin
                sum_reg <= sum_next;
                cnt_reg <= cnt_reg + 1'b1;
            end
            if (run && done)
            begin
                avg <= RSQ_RSSI_W'(sum_next >>> fl_eff);
            end
        end
    end

endmodule

// ---- rtl/rsq_out_mux.sv ----
// Registered function selector for one general output pin.
// Assumes the selector code is stable configuration; unserved codes drive low.
`timescale 1ns/1ps
module rsq_out_mux
    import rsq_pkg::*;
(
    // Clock and reset.
    input  wire logic                   clk,
    input  wire logic                   nrst,
    // Selector.
    input  wire logic [RSQ_FUNC_W-1:0]  func,
    // Sources.
    input  wire logic                   carrier_sense,
    input  wire logic                   clear_channel,
    // Pin.
    output logic                        pin
);
    logic pin_next;

    assign pin_next = (func == RSQ_FUNC_CS)  ? carrier_sense :
                      (func == RSQ_FUNC_CCA) ? clear_channel :
                      1'b0;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin <= 1'b0;
        end
        else
        begin
            pin <= pin_next;
        end
    end

endmodule

// ---- test/rsq_chk.sv ----
// Concurrent checks on the ports of rsq_top.
// Assumes one clock, reset active low.
`timescale 1ns/1ps
module rsq_chk
    import rsq_pkg::*;
(
    // Clock, reset and inputs.
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       rx_state,
    input wire logic       transmit_strobe,
    input wire logic       synth_on_strobe,
    input wire rsq_byte_t  rx_in,
    input wire logic       payload_end,
    // Outputs.
    input wire rsq_byte_t  rx_fifo_wr,
    input wire rsq_byte_t  status_byte,
    input wire logic       pkt_filter_en,
    input wire logic       sync_found,
    input wire logic [7:0] rssi_status,
    input wire logic       carrier_sense,
    input wire logic       sense_status_bit,
    input wire logic       clear_channel,
    input wire logic       enter_tx,
    input wire logic       enter_synth_ready_state,
    input wire logic       strobe_refused
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_fifo_gated: assert property (
        rx_fifo_wr.valid |-> $past(rx_in.valid) && $past(pkt_filter_en))
        else $error("Write outside packet.");
    a_status_src: assert property (
        status_byte.valid |-> $past(payload_end))
        else $error("Stray status byte.");
    a_rssi_hold: assert property (
        sync_found ##1 rx_state [*2] |-> $stable(rssi_status))
        else $error("Strength not held.");
    a_sense_idle: assert property (
        !rx_state [*3] |-> !carrier_sense)
        else $error("Sense outside receive.");
    a_sense_mirror: assert property (
        sense_status_bit == carrier_sense)
        else $error("Status bit mismatch.");
    a_strobe_once: assert property (
        transmit_strobe || synth_on_strobe |=>
        $onehot({enter_tx, enter_synth_ready_state, strobe_refused}))
        else $error("Strobe answer count.");
    a_no_late: assert property (
        !(transmit_strobe || synth_on_strobe) |=>
        !(enter_tx || enter_synth_ready_state || strobe_refused))
        else $error("Request without strobe.");
    a_busy_refuse: assert property (
        transmit_strobe && rx_state && $past(rx_state) && !clear_channel |=> strobe_refused)
        else $error("Busy strobe honoured.");
    a_idle_honour: assert property (
        transmit_strobe && !rx_state |=> enter_tx)
        else $error("Idle strobe refused.");
endmodule

bind rsq_top rsq_chk rsq_chk_inst (.*);

// ---- test/rsq_host.sv ----
// Host model that issues transmit and synth strobes.
// Assumes strobes change at the falling edge.
`timescale 1ns/1ps
module rsq_host
(
    // Clock.
    input  wire logic clk,
    // Strobes.
    output logic      transmit_strobe,
    output logic      synth_on_strobe
);
    initial
    begin
        transmit_strobe = 1'h0;
        synth_on_strobe = 1'h0;
    end

    // One strobe per call; never repeated by itself.
    task automatic strobe(input logic tx);
        @(negedge clk);
        transmit_strobe = tx;
        synth_on_strobe = !tx;
        @(negedge clk);
        transmit_strobe = 1'h0;
        synth_on_strobe = 1'h0;
    endtask
endmodule

// ---- test/rx_signal_qualifier_cca_test.sv ----
// Self-checking bench for rsq_top.
// Assumes rsq_host drives strobes; rsq_chk is bound.
`timescale 1ns/1ps
module rx_signal_qualifier_cca_test;
    import rsq_pkg::*;
    logic       clk = 1'h0, nrst = 1'h0, cfg_load = 1'h0, rx_state = 1'h0;
    logic       level_valid = 1'h0, sync_cand = 1'h0, payload_end = 1'h0;
    logic [7:0] sense_base_thr = 8'h20, level = 8'h00;
    logic [5:0] sync_match = 6'h00;
    rsq_cfg_t   cfg_in = RSQ_CFG_RST;
    rsq_byte_t  rx_in = '0, rx_fifo_wr, status_byte;
    logic       pkt_filter_en, sync_found, carrier_sense, sense_status_bit;
    logic       clear_channel, enter_tx, enter_synth_ready_state, strobe_refused;
    logic       transmit_strobe, synth_on_strobe;
    logic [7:0] rssi_status;
    logic [2:0] general_output_pin;
    logic [2:0] q_ans[$];
    logic [7:0] q_byte[$];
    int         n_mismatch = 0, tests_run = 0, seed = 33146;

    rsq_top rsq_top_inst (.*);
    rsq_host rsq_host_inst (.*);

    always #2 clk = ~clk;

    task automatic chk8(string what, logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chkb(string what, logic e, logic g);
        chk8(what, 8'(e), 8'(g));
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic setcfg();
        @(negedge clk);
        cfg_load = 1'h1;
        @(negedge clk);
        cfg_load = 1'h0;
        tick(2);
    endtask
    task automatic samp(logic [7:0] v);
        @(negedge clk);
        level_valid = 1'h1;
        level = v;
        @(negedge clk);
        level_valid = 1'h0;
        tick(4);
    endtask
    task automatic cand(logic [5:0] m);
        @(negedge clk);
        sync_cand = 1'h1;
        sync_match = m;
        @(negedge clk);
        sync_cand = 1'h0;
        tick(1);
    endtask
    task automatic byte_in(logic [7:0] v);
        @(negedge clk);
        rx_in = '{1'h1, v};
        @(negedge clk);
        rx_in.valid = 1'h0;
    endtask
    task automatic strb(logic tx, logic [2:0] e);
        q_ans.push_back(e);
        rsq_host_inst.strobe(tx);
        tick(2);
    endtask
    task automatic finish_test();
        chk8("left", 8'h00, 8'(q_ans.size() + q_byte.size()));
        $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(negedge clk)
    begin
        if (enter_tx || enter_synth_ready_state || strobe_refused)
            chk8("strobe", {5'h00, q_ans.size() ? q_ans.pop_front() : 3'h0},
                {5'h00, enter_tx, enter_synth_ready_state, strobe_refused});
        if (rx_fifo_wr.valid || status_byte.valid)
            chk8("rx byte", q_byte.size() ? q_byte.pop_front() : 8'hxx,
                rx_fifo_wr.valid ? rx_fifo_wr.data : status_byte.data);
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end

    initial
    begin
        logic [79:0] t_lv = 80'h2f2e2b1312201d1e30f0;
        logic [9:0]  t_cs = 10'h246;
        logic [26:0] t_md = 27'h7b1b488;
        logic [53:0] t_mt = 54'h1e3c079d40f3c0;
        logic [8:0]  t_ex = 9'h0ab;
        logic [7:0]  st[4] = '{8'h1c, 8'h0c, 8'h14, 8'h1c};
        logic [7:0]  d;
        tick(10);
        nrst = 1'h1;
        rx_state = 1'h1;
        samp(8'h21);
        chkb("cs one", 1'h0, carrier_sense);
        samp(8'h21);
        chk8("rssi", 8'h21, rssi_status);
        chkb("cs rst", 1'h1, carrier_sense);
        $display("Test reset done");
        cfg_in.filter_len = 2'h0;
        cfg_in.clear_channel_select = RSQ_CCA_RSSI;
        cfg_in.output_pin_function = {6'h00, RSQ_FUNC_CCA, RSQ_FUNC_CS};
        for (int i = 0; i < 10; i++)
        begin
            cfg_in.absolute_sense_offset = i < 5 ? 4'sh0 : i < 7 ? -4'sh7 : 4'sh7;
            setcfg();
            samp(t_lv[8*i +: 8]);
            chk8("rssi", t_lv[8*i +: 8], rssi_status);
            chkb("cs", t_cs[i], carrier_sense);
            chkb("cs bit", t_cs[i], sense_status_bit);
            chk8("pins", {6'h00, !t_cs[i], t_cs[i]}, 8'(general_output_pin));
        end
        $display("Test absolute done");
        cfg_in.absolute_sense_offset = RSQ_ABS_OFF_DIS;
        for (int k = 0; k < 4; k++)
        begin
            cfg_in.relative_sense_step = k[1:0];
            setcfg();
            rx_state = 1'h0;
            tick(3);
            rx_state = 1'h1;
            samp(8'h00);
            samp(st[k] - 8'h01);
            chkb("rise lo", 1'h0, carrier_sense);
            samp(st[k] + st[k] - 8'h01);
            chkb("rise", k != 0, carrier_sense);
            samp(st[k]);
            chkb("drop lo", k != 0, carrier_sense);
            samp(8'h00);
            chkb("drop", 1'h0, carrier_sense);
        end
        $display("Test relative done");
        cfg_in.absolute_sense_offset = RSQ_ABS_OFF_ZERO;
        cfg_in.relative_sense_step = RSQ_REL_OFF;
        setcfg();
        samp(8'h30);
        for (int m = 0; m < 4; m++)
        begin
            cfg_in.clear_channel_select = m[1:0];
            setcfg();
            strb(1'h1, m[0] ? 3'h1 : 3'h4);
        end
        samp(8'h1d);
        strb(1'h1, 3'h4);
        strb(1'h0, 3'h2);
        rx_state = 1'h0;
        tick(2);
        strb(1'h1, 3'h4);
        $display("Test cca done");
        for (int i = 0; i < 9; i++)
        begin
            cfg_in.sync_mode = t_md[3*i +: 3];
            setcfg();
            rx_state = 1'h1;
            tick(2);
            if (i == 7)
                samp(8'h30);
            cand(t_mt[6*i +: 6]);
            chkb("sync", t_ex[i], pkt_filter_en);
            rx_state = 1'h0;
            tick(3);
        end
        $display("Test sync done");
        cfg_in.sync_mode = 3'h2;
        setcfg();
        rx_state = 1'h1;
        samp(8'h30);
        byte_in(8'h5a);
        cand(6'h10);
        samp(8'h10);
        chk8("held rssi", 8'h30, rssi_status);
        for (int j = 0; j < 3; j++)
        begin
            d = 8'($random(seed));
            q_byte.push_back(d);
            byte_in(d);
        end
        q_byte.push_back(8'h10);
        @(negedge clk);
        payload_end = 1'h1;
        @(negedge clk);
        payload_end = 1'h0;
        tick(3);
        rx_state = 1'h0;
        tick(2);
        rx_state = 1'h1;
        samp(8'h05);
        chk8("reentry rssi", 8'h05, rssi_status);
        $display("Test packet done");
        finish_test();
    end
endmodule
